// ==== design/dsf_regs.svh ====
/*
 * offsets, field positions, reset values and feature masks of the
 * status and feature negotiation block.
 * assumes inclusion by bare name from the package and the design files.
 */
// Behaviour
// - status bit 0 = guest found device, bit 1 = knows driver, bit 3 = features ok
// - status bit 2 = driver ready, bit 6 = needs reset, bit 7 = gave up
// - every device reset loads the status field with zero, except that ERR_IN high in the same cycle as a zero write still sets bit 6
// - no buffer consumed and no notification sent before driver ready
// - unrecoverable device error sets the needs reset status bit
// - needs reset raised while driver ready sends config change notification
// - device presents every supported feature; driver writes back accepted subset
// - negotiated features change only through a reset, or after a nonzero status write clears features ok, and new negotiation
// - feature bits 0-23 device specific, 24-32 extensions, 33 up reserved
// - an added config field is announced by its own offered feature bit
// - device refuses to latch features ok for an unacceptable subset
// - config fields stay readable before features ok is set
`ifndef DSF_REGS_SVH
`define DSF_REGS_SVH

// ==========================================================
// register offsets
`define DSF_OFF_OFFER_SEL   8'h00
`define DSF_OFF_OFFER_WORD  8'h04
`define DSF_OFF_ACCEPT_SEL  8'h08
`define DSF_OFF_ACCEPT_WORD 8'h0c
`define DSF_OFF_STATUS      8'h10

// ==========================================================
// status field
`define DSF_ST_FOUND     0
`define DSF_ST_KNOWS     1
`define DSF_ST_READY     2
`define DSF_ST_FEAT_OK   3
`define DSF_ST_NEED_RST  6
`define DSF_ST_GAVE_UP   7
`define DSF_ST_MASK      8'hcf
`define DSF_STATUS_RST   8'h00

// ==========================================================
// features
`define DSF_FEAT_DEV_HI    23
`define DSF_FEAT_EXT_LO    24
`define DSF_FEAT_EXT_HI    32
`define DSF_FEAT_FUT_LO    33
`define DSF_FEAT_LEGAL     64'h0000_0001_ffff_ffff
`define DSF_FEAT_OFFER     64'h0000_0001_0000_0007
`define DSF_FEAT_CFG_EXT   2
`define DSF_FEAT_NEED      64'h0000_0000_0000_0004
`define DSF_FEAT_PREREQ    64'h0000_0000_0000_0002
`define DSF_FEAT_RST       64'h0000_0000_0000_0000

`endif

// ==== design/dsf_pkg.sv ====
/*
 * types and the register decode function of the block.
 * assumes dsf_regs.svh on the include path.
 */
`include "dsf_regs.svh"
package dsf_pkg;
	typedef logic [7:0]  dsf_status_t;
	typedef logic [31:0] dsf_word_t;
	typedef logic [63:0] dsf_feat_t;
	typedef enum {DSF_REG_NONE, DSF_REG_OFFER_SEL, DSF_REG_OFFER_WORD,
		DSF_REG_ACCEPT_SEL, DSF_REG_ACCEPT_WORD, DSF_REG_STATUS} dsf_reg_t;

	// ==========================================================
	// address decode
	function automatic dsf_reg_t dsf_decode(input logic [7:0] addr);
		dsf_reg_t r;
		r = DSF_REG_NONE;
		unique case (addr)
			`DSF_OFF_OFFER_SEL:   r = DSF_REG_OFFER_SEL;
			`DSF_OFF_OFFER_WORD:  r = DSF_REG_OFFER_WORD;
			`DSF_OFF_ACCEPT_SEL:  r = DSF_REG_ACCEPT_SEL;
			`DSF_OFF_ACCEPT_WORD: r = DSF_REG_ACCEPT_WORD;
			`DSF_OFF_STATUS:      r = DSF_REG_STATUS;
			default:              r = DSF_REG_NONE;
		endcase
		return r;
	endfunction : dsf_decode
endpackage : dsf_pkg

// ==== design/dsf_feature_bank.sv ====
/*
 * accepted feature set, two 32-bit halves, with lock and validity check.
 * assumes clock and synchronous active-low reset of the top module.
 */
`timescale 1ns/1ps
`include "dsf_regs.svh"
module dsf_feature_bank
	import dsf_pkg::*;
(
	input  wire logic      clk_in,
	input  wire logic      rst_n_in,
	input  wire logic      clear_in,
	input  wire logic      wr_in,
	input  wire logic      sel_in,
	input  wire dsf_word_t wdata_in,
	input  wire logic      lock_in,
	output dsf_feat_t      accepted_out,
	output logic           valid_out
);
	dsf_feat_t acc_reg;
	dsf_feat_t acc_next;

	// ==========================================================
	// halves
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_half
			always_comb
			begin
				acc_next[g*32 +: 32] = acc_reg[g*32 +: 32];
				if (clear_in)
					acc_next[g*32 +: 32] = 32'h0000_0000;
				else if (wr_in && !lock_in && (sel_in == 1'(g)))
					acc_next[g*32 +: 32] = wdata_in;
			end
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			acc_reg <= `DSF_FEAT_RST;
		else
			acc_reg <= acc_next;
	end

	// ==========================================================
	// acceptability
	always_comb
	begin
		valid_out = ((acc_reg & ~`DSF_FEAT_OFFER) == `DSF_FEAT_RST)
			&& (((acc_reg & `DSF_FEAT_NEED) == `DSF_FEAT_RST)
			|| ((acc_reg & `DSF_FEAT_PREREQ) == `DSF_FEAT_PREREQ));
	end

	assign accepted_out = acc_reg;
endmodule : dsf_feature_bank

// ==== design/dsf_event_gate.sv ====
/*
 * gates buffer grants and notifications on driver ready, and forms the
 * config change notification pulse.
 * assumes same-clock requests from the device core.
 */
`timescale 1ns/1ps
module dsf_event_gate
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ready_in,
	input  wire logic buf_req_in,
	input  wire logic ntf_req_in,
	input  wire logic raise_in,
	output logic      buf_grant_out,
	output logic      notify_out,
	output logic      cfg_change_out
);
	logic grant_reg;
	logic grant_next;
	logic ntf_reg;
	logic ntf_next;
	logic cfg_reg;
	logic cfg_next;

	// ==========================================================
	// gating
	always_comb
	begin
		grant_next = buf_req_in && ready_in;
		ntf_next   = ntf_req_in && ready_in;
		cfg_next   = raise_in && ready_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			grant_reg <= 1'b0;
			ntf_reg   <= 1'b0;
			cfg_reg   <= 1'b0;
		end
		else
		begin
			grant_reg <= grant_next;
			ntf_reg   <= ntf_next;
			cfg_reg   <= cfg_next;
		end
	end

	assign buf_grant_out  = grant_reg;
	assign notify_out     = ntf_reg;
	assign cfg_change_out = cfg_reg;
endmodule : dsf_event_gate

// ==== design/dsf_status_feature.sv ====
/*
 * top of the status and feature negotiation block: register port,
 * status field, feature offer and acceptance, event gating.
 * assumes a same-clock register master and same-clock device core inputs.
 */
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "dsf_regs.svh"
module dsf_status_feature
	import dsf_pkg::*;
(
	input  wire logic       CLK_IN,
	input  wire logic       RST_N_IN,
	input  wire logic [7:0] REG_ADDR_IN,
	input  wire dsf_word_t  REG_WDATA_IN,
	input  wire logic       REG_WR_IN,
	input  wire logic       REG_RD_IN,
	input  wire logic       ERR_IN,
	input  wire logic       BUF_REQ_IN,
	input  wire logic       NOTIFY_REQ_IN,
	output dsf_word_t       REG_RDATA_OUT,
	output dsf_status_t     STATUS_OUT,
	output dsf_feat_t       FEAT_ACCEPTED_OUT,
	output logic            BUF_GRANT_OUT,
	output logic            NOTIFY_OUT,
	output logic            CFG_CHANGE_OUT
);
	// ==========================================================
	// decode
	dsf_reg_t    wr_reg;
	dsf_reg_t    rd_reg;
	logic        status_wr;
	logic        soft_rst;
	logic        accept_wr;
	logic        feat_valid;
	logic        raise_err;
	dsf_feat_t   accepted;
	dsf_feat_t   offered;

	dsf_status_t status_reg;
	dsf_status_t status_next;
	logic        offer_sel_reg;
	logic        offer_sel_next;
	logic        accept_sel_reg;
	logic        accept_sel_next;
	dsf_word_t   rdata_reg;
	dsf_word_t   rdata_next;

	always_comb
	begin
		wr_reg    = REG_WR_IN ? dsf_decode(REG_ADDR_IN) : DSF_REG_NONE;
		rd_reg    = REG_RD_IN ? dsf_decode(REG_ADDR_IN) : DSF_REG_NONE;
		status_wr = (wr_reg == DSF_REG_STATUS);
		soft_rst  = status_wr && (REG_WDATA_IN[7:0] == `DSF_STATUS_RST);
		accept_wr = (wr_reg == DSF_REG_ACCEPT_WORD);
		offered   = `DSF_FEAT_OFFER & `DSF_FEAT_LEGAL;
		raise_err = ERR_IN && !status_reg[`DSF_ST_NEED_RST];
	end

	// ==========================================================
	// status field
	always_comb
	begin
		status_next = status_reg;
		if (soft_rst)
			status_next = `DSF_STATUS_RST;
		else if (status_wr)
		begin
			status_next = REG_WDATA_IN[7:0] & `DSF_ST_MASK;
			status_next[`DSF_ST_FEAT_OK] = REG_WDATA_IN[`DSF_ST_FEAT_OK]
				&& (status_reg[`DSF_ST_FEAT_OK] || feat_valid);
			status_next[`DSF_ST_NEED_RST] = status_reg[`DSF_ST_NEED_RST];
		end
		if (ERR_IN)
			status_next[`DSF_ST_NEED_RST] = 1'b1;
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
			status_reg <= `DSF_STATUS_RST;
		else
			status_reg <= status_next;
	end

	// ==========================================================
	// selectors
	always_comb
	begin
		offer_sel_next  = offer_sel_reg;
		accept_sel_next = accept_sel_reg;
		if (wr_reg == DSF_REG_OFFER_SEL)
			offer_sel_next = REG_WDATA_IN[0];
		if (wr_reg == DSF_REG_ACCEPT_SEL)
			accept_sel_next = REG_WDATA_IN[0];
		if (soft_rst)
		begin
			offer_sel_next  = 1'b0;
			accept_sel_next = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			offer_sel_reg  <= 1'b0;
			accept_sel_reg <= 1'b0;
		end
		else
		begin
			offer_sel_reg  <= offer_sel_next;
			accept_sel_reg <= accept_sel_next;
		end
	end

	// ==========================================================
	// read port, never gated by status
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		unique case (rd_reg)
			DSF_REG_OFFER_SEL:   rdata_next = {31'h0000_0000, offer_sel_reg};
			DSF_REG_OFFER_WORD:  rdata_next = offered[offer_sel_reg*32 +: 32];
			DSF_REG_ACCEPT_SEL:  rdata_next = {31'h0000_0000, accept_sel_reg};
			DSF_REG_ACCEPT_WORD: rdata_next = accepted[accept_sel_reg*32 +: 32];
			DSF_REG_STATUS:      rdata_next = {24'h00_0000, status_reg};
			DSF_REG_NONE:        rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= rdata_next;
	end

	// ==========================================================
	// features and events
	dsf_feature_bank u_bank (
		.clk_in       (CLK_IN),
		.rst_n_in     (RST_N_IN),
		.clear_in     (soft_rst),
		.wr_in        (accept_wr),
		.sel_in       (accept_sel_reg),
		.wdata_in     (REG_WDATA_IN),
		.lock_in      (status_reg[`DSF_ST_FEAT_OK]),
		.accepted_out (accepted),
		.valid_out    (feat_valid)
	);

	dsf_event_gate u_gate (
		.clk_in         (CLK_IN),
		.rst_n_in       (RST_N_IN),
		.ready_in       (status_reg[`DSF_ST_READY]),
		.buf_req_in     (BUF_REQ_IN),
		.ntf_req_in     (NOTIFY_REQ_IN),
		.raise_in       (raise_err),
		.buf_grant_out  (BUF_GRANT_OUT),
		.notify_out     (NOTIFY_OUT),
		.cfg_change_out (CFG_CHANGE_OUT)
	);

	assign REG_RDATA_OUT     = rdata_reg;
	assign STATUS_OUT        = status_reg;
	assign FEAT_ACCEPTED_OUT = accepted;

	// ==========================================================
	// assertions
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	sequence s_err_rise;
		ERR_IN && !status_reg[`DSF_ST_NEED_RST] && status_reg[`DSF_ST_READY];
	endsequence

	sequence s_cfg_pulse;
		CFG_CHANGE_OUT ##1 !CFG_CHANGE_OUT;
	endsequence

	sequence s_bad_feat_ok;
		status_wr && REG_WDATA_IN[`DSF_ST_FEAT_OK] && !ERR_IN
			&& !status_reg[`DSF_ST_FEAT_OK] && !feat_valid && !soft_rst;
	endsequence

	a_reset_status_zero: assert property (disable iff (1'b0)
		!RST_N_IN |=> (STATUS_OUT == 8'h00) && !BUF_GRANT_OUT && !NOTIFY_OUT)
		else $error("status not zero after reset");

	a_grant_needs_ready: assert property (
		BUF_GRANT_OUT |-> $past(status_reg[`DSF_ST_READY]) && $past(BUF_REQ_IN))
		else $error("buffer granted before driver ready");

	a_notify_needs_ready: assert property (
		!status_reg[`DSF_ST_READY] ##1 !status_reg[`DSF_ST_READY] |-> !NOTIFY_OUT)
		else $error("notification before driver ready");

	a_err_sets_flag: assert property (
		ERR_IN |=> status_reg[`DSF_ST_NEED_RST] [*2] or
			(status_reg[`DSF_ST_NEED_RST] ##1 (status_wr && REG_WDATA_IN[7:0] == 8'h00)))
		else $error("error did not set needs reset");

	a_cfg_change_pulse: assert property (s_err_rise |=> s_cfg_pulse)
		else $error("no config change notification");

	a_cfg_change_cause: assert property (
		CFG_CHANGE_OUT |-> $past(ERR_IN) && $past(status_reg[`DSF_ST_READY]))
		else $error("spurious config change notification");

	a_feat_ok_refused: assert property (
		s_bad_feat_ok |=> !status_reg[`DSF_ST_FEAT_OK])
		else $error("features ok latched for bad subset");

	a_feat_locked: assert property (
		status_reg[`DSF_ST_FEAT_OK] && !soft_rst |=> $stable(FEAT_ACCEPTED_OUT))
		else $error("features changed after negotiation");

	a_soft_reset_clear: assert property (
		soft_rst && !ERR_IN |=> (STATUS_OUT == 8'h00) && (FEAT_ACCEPTED_OUT == 64'h0))
		else $error("status zero write did not reset");

	a_offer_read: assert property (
		rd_reg == DSF_REG_OFFER_WORD |=>
			REG_RDATA_OUT == $past(offered[offer_sel_reg*32 +: 32]))
		else $error("offered feature word misread");

	a_reserved_zero: assert property ((STATUS_OUT & 8'h30) == 8'h00)
		else $error("reserved status bits set");
endmodule : dsf_status_feature

// ==== tb/tb.sv ====
/*
 * self-checking bench of the status and feature negotiation block.
 * assumes the design files and dsf_regs.svh on the include path.
 */
`timescale 1ns/1ps
`include "dsf_regs.svh"
module tb
	import dsf_pkg::*;
;
	localparam logic [63:0] OFFER = 64'h0000_0001_0000_0007;

	logic        CLK_IN        = 1'b0;
	logic        RST_N_IN      = 1'b0;
	logic [7:0]  REG_ADDR_IN   = 8'h00;
	dsf_word_t   REG_WDATA_IN  = 32'h0;
	logic        REG_WR_IN     = 1'b0;
	logic        REG_RD_IN     = 1'b0;
	logic        ERR_IN        = 1'b0;
	logic        BUF_REQ_IN    = 1'b0;
	logic        NOTIFY_REQ_IN = 1'b0;
	dsf_word_t   REG_RDATA_OUT;
	dsf_status_t STATUS_OUT;
	dsf_feat_t   FEAT_ACCEPTED_OUT;
	logic        BUF_GRANT_OUT;
	logic        NOTIFY_OUT;
	logic        CFG_CHANGE_OUT;
	int          failures      = 0;
	int          n_tests       = 0;
	dsf_feat_t   f;
	logic [7:0]  st;
	logic        b;

	// ==========================================================
	// clock and design
	always #12.5 CLK_IN = ~CLK_IN;

	dsf_status_feature u_dsf_status_feature (.CLK_IN, .RST_N_IN, .REG_ADDR_IN,
		.REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .ERR_IN, .BUF_REQ_IN,
		.NOTIFY_REQ_IN, .REG_RDATA_OUT, .STATUS_OUT, .FEAT_ACCEPTED_OUT,
		.BUF_GRANT_OUT, .NOTIFY_OUT, .CFG_CHANGE_OUT);

	// ==========================================================
	// helpers
	function automatic logic ok_set(input logic [63:0] fs);
		return ((fs & ~OFFER) == 64'h0) && (!fs[2] || fs[1]);
	endfunction : ok_set

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input dsf_word_t d);
		@(posedge CLK_IN);
		REG_WR_IN    <= 1'b1;
		REG_ADDR_IN  <= a;
		REG_WDATA_IN <= d;
		@(posedge CLK_IN);
		REG_WR_IN    <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input dsf_word_t exp, input string what);
		@(posedge CLK_IN);
		REG_RD_IN   <= 1'b1;
		REG_ADDR_IN <= a;
		@(posedge CLK_IN);
		REG_RD_IN   <= 1'b0;
		#1;
		chk(REG_RDATA_OUT, exp, what);
		@(posedge CLK_IN);
		#1;
		chk(REG_RDATA_OUT, 32'h0, "read data one cycle");
	endtask : rd

	task automatic accept(input logic [63:0] fs);
		wr(`DSF_OFF_ACCEPT_SEL, 32'h0);
		wr(`DSF_OFF_ACCEPT_WORD, fs[31:0]);
		wr(`DSF_OFF_ACCEPT_SEL, 32'h1);
		wr(`DSF_OFF_ACCEPT_WORD, fs[63:32]);
	endtask : accept

	task automatic ev(input logic bq, input logic nq, input logic rdy);
		@(posedge CLK_IN);
		BUF_REQ_IN    <= bq;
		NOTIFY_REQ_IN <= nq;
		@(posedge CLK_IN);
		BUF_REQ_IN    <= 1'b0;
		NOTIFY_REQ_IN <= 1'b0;
		#1;
		chk(BUF_GRANT_OUT, bq & rdy, "buffer grant");
		chk(NOTIFY_OUT, nq & rdy, "notify");
	endtask : ev

	task automatic err(input logic rdy);
		@(posedge CLK_IN);
		ERR_IN <= 1'b1;
		@(posedge CLK_IN);
		#1;
		chk(STATUS_OUT[6], 1'b1, "needs reset bit");
		chk(CFG_CHANGE_OUT, rdy, "config change pulse");
		@(posedge CLK_IN);
		ERR_IN <= 1'b0;
		#1;
		chk(CFG_CHANGE_OUT, 1'b0, "config change one cycle");
	endtask : err

	// ==========================================================
	// watchdog
	initial
	begin
		repeat (20000) @(posedge CLK_IN);
		failures++;
		$display("unexpected at %0t: run limit reached", $time);
		report_and_stop();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(72841));
		repeat (12) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		#1;
		chk(STATUS_OUT, 8'h00, "reset status");
		chk(FEAT_ACCEPTED_OUT, 64'h0, "reset features");
		ev(1'b1, 1'b1, 1'b0);
		err(1'b0);
		chk(STATUS_OUT, 8'h40, "needs reset value");
		wr(`DSF_OFF_STATUS, 32'h0);
		chk(STATUS_OUT, 8'h00, "soft reset");
		wr(`DSF_OFF_OFFER_SEL, 32'h0);
		rd(`DSF_OFF_OFFER_WORD, OFFER[31:0], "offer low");
		wr(`DSF_OFF_OFFER_SEL, 32'h1);
		rd(`DSF_OFF_OFFER_WORD, OFFER[63:32], "offer high");
		rd(8'h14, 32'h0, "unmapped read");
		wr(`DSF_OFF_STATUS, 32'h83);
		chk(STATUS_OUT, 8'h83, "gave up bit");
		wr(`DSF_OFF_STATUS, 32'h0);
		chk(STATUS_OUT, 8'h00, "reset after gave up");
		for (int i = 0; i < 12; i++)
		begin
			wr(`DSF_OFF_STATUS, 32'h0);
			chk(STATUS_OUT, 8'h00, "soft reset status");
			chk(FEAT_ACCEPTED_OUT, 64'h0, "soft reset features");
			wr(`DSF_OFF_STATUS, 32'h1);
			wr(`DSF_OFF_STATUS, 32'h3);
			chk(STATUS_OUT, 8'h03, "found and knows");
			f = {30'h0, 2'($urandom), 28'h0, 4'($urandom)};
			if (i == 0)
				f = 64'h4;
			if (i == 1)
				f = OFFER;
			accept(f);
			chk(FEAT_ACCEPTED_OUT, f, "accepted set");
			rd(`DSF_OFF_ACCEPT_WORD, f[63:32], "accepted high read");
			b = ok_set(f);
			wr(`DSF_OFF_STATUS, 32'h0b);
			chk(STATUS_OUT, b ? 8'h0b : 8'h03, "features ok gate");
			st = b ? 8'h0f : 8'h07;
			ev(1'($urandom), 1'($urandom), 1'b0);
			wr(`DSF_OFF_STATUS, {24'h0, st | 8'h40});
			chk(STATUS_OUT, st, "ready, bit 6 device owned");
			rd(`DSF_OFF_STATUS, {24'h0, st}, "status read");
			if (b)
			begin
				accept(64'h0);
				chk(FEAT_ACCEPTED_OUT, f, "locked set");
			end
			ev(1'($urandom), 1'($urandom), 1'b1);
			ev(1'b1, 1'b1, 1'b1);
		end
		err(1'b1);
		wr(`DSF_OFF_STATUS, 32'h0);
		chk(STATUS_OUT, 8'h00, "soft reset after error");
		wr(`DSF_OFF_STATUS, 32'h3);
		@(posedge CLK_IN);
		RST_N_IN <= 1'b0;
		repeat (2) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		#1;
		chk(STATUS_OUT, 8'h00, "second reset");
		report_and_stop();
	end
endmodule : tb
